// file: gocr_pkg.sv
// Purpose: Shared constants of the global operational control bank.
// Assumes: APB word per register, byte address is four times the index.
// Notes: Buffered fields move to their applied copy on a transfer strobe.
package gocr_pkg;
    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam int IDX_W = 12;
    localparam logic [11:0] IDX_GLOBAL = 12'hA00;
    localparam logic [11:0] IDX_REF_PD = 12'hA01;
    localparam logic [11:0] IDX_REF_TMO = 12'hA02;
    localparam logic [11:0] IDX_REF_FLT = 12'hA03;
    localparam logic [11:0] IDX_XFER = 12'h00F;
    localparam logic [11:0] IDX_STATUS = 12'h010;
    // ------------------------------------------------------------
    // Field layout and values
    // ------------------------------------------------------------
    localparam int REG_W = 8;
    localparam int NUM_REF = 4;
    localparam int NUM_OUTPUT_ANALOG_PLL = 4;
    localparam int BIT_SYNC_ALL = 3;
    localparam int BIT_CAL_SYS = 2;
    localparam int BIT_CAL_ALL = 1;
    localparam int BIT_PD_ALL = 0;
    localparam logic [7:0] XFER_GO = 8'h01;
    localparam logic [7:0] MASK_LOW4 = 8'h0F;
    localparam logic [7:0] RST_REG = 8'h00;
endpackage

// file: gocr_reg_if.sv
// Purpose: Carries decoded register accesses from the bus slave to the bank.
// Assumes: One access at a time.
// Notes: wr_stb is a one-cycle pulse at the completing APB edge.
interface gocr_reg_if;
    logic addr_ok;
    logic [gocr_pkg::IDX_W-1:0] idx;
    logic [gocr_pkg::REG_W-1:0] wdata;
    logic wr_stb;
    logic hit;
    logic [gocr_pkg::REG_W-1:0] rdata;
    modport slave (output addr_ok, idx, wdata, wr_stb, input hit, rdata);
    modport bank (input addr_ok, idx, wdata, wr_stb, output hit, rdata);
endinterface

// file: gocr_apb_slave.sv
// Purpose: APB slave front end with one wait state per transfer.
// Assumes: APB master holds the request until pready is seen high.
// Notes: Unmapped or unaligned addresses answer with pslverr.
module gocr_apb_slave (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    // APB answer
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Decoded access
    gocr_reg_if.slave rif
);
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } gocr_apb_s;

    gocr_apb_s st_ff;
    gocr_apb_s nxt_st;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Word aligned and inside the index range
    assign rif.addr_ok = (paddr[1:0] == 2'h0) && (paddr[15:14] == 2'h0);
    assign rif.idx = paddr[13:2];
    assign rif.wdata = pwdata[7:0];
    // Write lands only at the edge that completes the access
    assign rif.wr_stb = psel & penable & st_ff.pready & pwrite & rif.hit;

    // ------------------------------------------------------------
    // Answer
    // ------------------------------------------------------------
    // Raise pready one cycle into the access phase, for one cycle
    always_comb begin
        nxt_st = st_ff;
        nxt_st.pready = 1'b0;
        nxt_st.pslverr = 1'b0;
        if (psel && penable && !st_ff.pready) begin
            nxt_st.pready = 1'b1;
            nxt_st.pslverr = !rif.hit;
            nxt_st.prdata = (!pwrite && rif.hit) ? {24'h000000, rif.rdata} : 32'h00000000;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
endmodule

// file: gocr_ref_chan.sv
// Purpose: Fault, usability and validation control of one reference input.
// Assumes: Monitor fault and bypass are synchronous levels.
// Notes: A forced fault beats the monitor bypass.
module gocr_ref_chan (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Controls
    input wire logic force_fault,
    input wire logic power_down,
    input wire logic timeout_hit,
    // Monitor
    input wire logic monitor_fault,
    input wire logic monitor_bypass,
    // Status
    output logic faulted,
    output logic usable,
    output logic valid_now
);
    typedef struct packed {
        logic faulted;
        logic usable;
        logic valid_now;
    } gocr_ref_s;

    gocr_ref_s st_ff;
    gocr_ref_s nxt_st;
    logic flt_now;

    // Effective fault: forced fault first, then unbypassed monitor
    assign flt_now = force_fault | (monitor_fault & ~monitor_bypass); // [R12] [R14]

    // Next channel state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.faulted = flt_now;
        nxt_st.usable = ~flt_now & ~power_down; // [R12] [R9]
        nxt_st.valid_now = timeout_hit & ~flt_now; // [R10]
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign faulted = st_ff.faulted;
    assign usable = st_ff.usable;
    assign valid_now = st_ff.valid_now;
endmodule

// file: gocr_top.sv
// Purpose: Global operational control bank of a multi-channel clock generator.
// Assumes: APB master, one clock, inputs synchronous to pclk.
// Notes: Global, power-down and fault fields are buffered until the strobe.
//
// Notes on behaviour
// (R1) Soft sync bit starts sync of outputs
// (R2) Unmasked outputs stall; restart on falling bit
// (R3) Buffered changes apply only on strobe 0x01
// (R4) Rising system calibrate bit calibrates system PLL
// (R5) Rising calibrate-all calibrates system and output PLLs
// (R6) Software clears calibrate-all; hardware never does
// (R7) Calibrate-all masks per-PLL calibration requests
// (R8) Power-down-all bit sleeps device; resets powered
// (R9) Per-reference receiver power-down, reset powered
// (R10) Timeout bit validates an unfaulted reference now
// (R11) Timeout bits self clear, reset zero
// (R12) Forced fault marks reference unusable, reset zero
// (R13) Upper four bits reserved, reset zero
// (R14) Forced fault overrides monitor bypass
// (R15) Reserved bits read zero, writes ignored
module gocr_top #(
    parameter int NUM_OUT = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    // APB answer
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Output synchronisation
    input wire logic [NUM_OUT-1:0] sync_mask,
    output logic [NUM_OUT-1:0] sync_stall,
    output logic sync_start,
    output logic sync_restart,
    // Calibration
    input wire logic [gocr_pkg::NUM_OUTPUT_ANALOG_PLL-1:0] output_analog_pll_cal_req,
    output logic [gocr_pkg::NUM_OUTPUT_ANALOG_PLL-1:0] output_analog_pll_cal_start,
    output logic system_clock_pll_cal_start,
    // Power
    output logic device_sleep,
    output logic [gocr_pkg::NUM_REF-1:0] ref_power_down,
    // Reference monitors
    input wire logic [gocr_pkg::NUM_REF-1:0] ref_monitor_fault,
    input wire logic [gocr_pkg::NUM_REF-1:0] ref_monitor_bypass,
    output logic [gocr_pkg::NUM_REF-1:0] ref_faulted,
    output logic [gocr_pkg::NUM_REF-1:0] ref_usable,
    output logic [gocr_pkg::NUM_REF-1:0] ref_valid_now
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] glb_live;
        logic [7:0] pd_live;
        logic [7:0] flt_live;
        logic [7:0] glb_act;
        logic [7:0] pd_act;
        logic [7:0] flt_act;
        logic [3:0] tmo_hit;
        logic [NUM_OUT-1:0] stall;
        logic sync_start;
        logic sync_restart;
        logic sys_cal;
        logic [3:0] output_analog_pll_cal;
    } gocr_bank_s;

    gocr_bank_s st_ff;
    gocr_bank_s nxt_st;
    logic [3:0] chan_faulted;
    logic [3:0] chan_usable;
    logic [3:0] chan_valid;
    logic cal_all_rise;
    logic cal_sys_rise;

    gocr_reg_if rif ();

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    // APB front end
    gocr_apb_slave u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .rif(rif)
    );

    // Mapped indices
    always_comb begin
        case (rif.idx)
            gocr_pkg::IDX_GLOBAL,
            gocr_pkg::IDX_REF_PD,
            gocr_pkg::IDX_REF_TMO,
            gocr_pkg::IDX_REF_FLT,
            gocr_pkg::IDX_XFER,
            gocr_pkg::IDX_STATUS: rif.hit = rif.addr_ok;
            default: rif.hit = 1'b0;
        endcase
    end

    // Read mux; strobe and timeout read zero as they self clear
    always_comb begin
        case (rif.idx)
            gocr_pkg::IDX_GLOBAL: rif.rdata = st_ff.glb_live; // [R15]
            gocr_pkg::IDX_REF_PD: rif.rdata = st_ff.pd_live;
            gocr_pkg::IDX_REF_FLT: rif.rdata = st_ff.flt_live;
            gocr_pkg::IDX_STATUS: rif.rdata = {chan_usable, chan_faulted};
            default: rif.rdata = gocr_pkg::RST_REG; // [R11]
        endcase
    end

    // ------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------
    // Writes, strobe transfer and derived pulses
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tmo_hit = 4'h0;
        if (rif.wr_stb) begin
            case (rif.idx)
                gocr_pkg::IDX_GLOBAL: begin
                    nxt_st.glb_live = rif.wdata & gocr_pkg::MASK_LOW4; // [R13] [R15]
                end
                gocr_pkg::IDX_REF_PD: begin
                    nxt_st.pd_live = rif.wdata & gocr_pkg::MASK_LOW4; // [R15]
                end
                gocr_pkg::IDX_REF_FLT: begin
                    nxt_st.flt_live = rif.wdata & gocr_pkg::MASK_LOW4; // [R15]
                end
                gocr_pkg::IDX_REF_TMO: begin
                    nxt_st.tmo_hit = rif.wdata[3:0]; // [R10] [R11]
                end
                gocr_pkg::IDX_XFER: begin
                    if (rif.wdata == gocr_pkg::XFER_GO) begin
                        nxt_st.glb_act = st_ff.glb_live; // [R3]
                        nxt_st.pd_act = st_ff.pd_live; // [R3]
                        nxt_st.flt_act = st_ff.flt_live; // [R3]
                    end
                end
                default: begin
                    nxt_st.tmo_hit = 4'h0;
                end
            endcase
        end
        // Sync start on rising applied bit, restart on falling
        nxt_st.sync_start = !st_ff.glb_act[gocr_pkg::BIT_SYNC_ALL]
            && nxt_st.glb_act[gocr_pkg::BIT_SYNC_ALL]; // [R1]
        nxt_st.sync_restart = st_ff.glb_act[gocr_pkg::BIT_SYNC_ALL]
            && !nxt_st.glb_act[gocr_pkg::BIT_SYNC_ALL]; // [R2]
        nxt_st.stall = {NUM_OUT{nxt_st.glb_act[gocr_pkg::BIT_SYNC_ALL]}} & ~sync_mask; // [R1] [R2]
        // Calibrate edges on the applied copy, so only a strobe can raise them
        cal_sys_rise = !st_ff.glb_act[gocr_pkg::BIT_CAL_SYS]
            && nxt_st.glb_act[gocr_pkg::BIT_CAL_SYS]; // [R4]
        cal_all_rise = !st_ff.glb_act[gocr_pkg::BIT_CAL_ALL]
            && nxt_st.glb_act[gocr_pkg::BIT_CAL_ALL]; // [R5]
        // Calibration pulses
        nxt_st.sys_cal = cal_sys_rise | cal_all_rise; // [R4] [R5]
        if (cal_all_rise) begin
            nxt_st.output_analog_pll_cal = 4'hF; // [R5]
        end else if (nxt_st.glb_act[gocr_pkg::BIT_CAL_ALL]) begin
            nxt_st.output_analog_pll_cal = 4'h0; // [R7] [R6]
        end else begin
            nxt_st.output_analog_pll_cal = output_analog_pll_cal_req;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0; // [R8] [R9] [R12] [R13]
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Reference channels
    // ------------------------------------------------------------
    // One control slice per reference input
    generate
        for (genvar i = 0; i < gocr_pkg::NUM_REF; i++) begin : g_ref
            gocr_ref_chan u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .force_fault(st_ff.flt_act[i]), // [R12] [R14]
                .power_down(st_ff.pd_act[i]),
                .timeout_hit(st_ff.tmo_hit[i]), // [R10]
                .monitor_fault(ref_monitor_fault[i]),
                .monitor_bypass(ref_monitor_bypass[i]),
                .faulted(chan_faulted[i]),
                .usable(chan_usable[i]),
                .valid_now(chan_valid[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output is a flip-flop of the bank, of a slice or of the APB front end
    assign sync_stall = st_ff.stall;
    assign sync_start = st_ff.sync_start;
    assign sync_restart = st_ff.sync_restart;
    assign system_clock_pll_cal_start = st_ff.sys_cal;
    assign output_analog_pll_cal_start = st_ff.output_analog_pll_cal;
    assign device_sleep = st_ff.glb_act[gocr_pkg::BIT_PD_ALL]; // [R8]
    assign ref_power_down = st_ff.pd_act[3:0]; // [R9]
    assign ref_faulted = chan_faulted;
    assign ref_usable = chan_usable;
    assign ref_valid_now = chan_valid;
endmodule

// file: gocr_asserts.sv
// Purpose: Port-level checks of the global control bank.
// Assumes: One pclk domain, presetn async active low.
// Notes: Bound onto gocr_top below the module.
module gocr_asserts #(
    parameter int NUM_OUT = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Controlled outputs and monitors
    input wire logic [NUM_OUT-1:0] sync_mask,
    input wire logic [NUM_OUT-1:0] sync_stall,
    input wire logic sync_start,
    input wire logic sync_restart,
    input wire logic [gocr_pkg::NUM_OUTPUT_ANALOG_PLL-1:0] output_analog_pll_cal_req,
    input wire logic [gocr_pkg::NUM_OUTPUT_ANALOG_PLL-1:0] output_analog_pll_cal_start,
    input wire logic system_clock_pll_cal_start,
    input wire logic [gocr_pkg::NUM_REF-1:0] ref_monitor_fault,
    input wire logic [gocr_pkg::NUM_REF-1:0] ref_monitor_bypass,
    input wire logic [gocr_pkg::NUM_REF-1:0] ref_faulted,
    input wire logic [gocr_pkg::NUM_REF-1:0] ref_valid_now
);
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_SYNC_START: assert property (sync_start |-> sync_stall == ~$past(sync_mask))
        else $error("stall pattern wrong at sync start");
    AST_SYNC_PULSE: assert property (sync_start |=> !sync_start)
        else $error("sync start not a pulse");
    AST_SYNC_RESTART: assert property (sync_restart |-> sync_stall == '0)
        else $error("outputs still stalled at restart");
    AST_CAL_ALL: assert property ((&output_analog_pll_cal_start && !$past(&output_analog_pll_cal_req)) |-> system_clock_pll_cal_start)
        else $error("calibrate all without system calibration");
    AST_OUTPUT_ANALOG_PLL_FWD: assert property ((output_analog_pll_cal_start != 0 && !system_clock_pll_cal_start)
        |-> output_analog_pll_cal_start == $past(output_analog_pll_cal_req))
        else $error("output pll calibration start wrong");
    AST_READY_TIME: assert property ((psel && penable && !$past(penable)) |=> pready)
        else $error("pready late");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_RDATA_RSV: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    AST_FAULT: assert property (($past(ref_monitor_fault & ~ref_monitor_bypass) & ~ref_faulted) == 0)
        else $error("monitor fault not reported");
    AST_VALID_PULSE: assert property (ref_valid_now != 0 |=> ref_valid_now == 0)
        else $error("validation pulse held");
    // Main scenarios seen
    COV_SYNC: cover property (sync_start);
    COV_CAL: cover property (&output_analog_pll_cal_start);
    COV_VALID: cover property (ref_valid_now != 0);
endmodule

bind gocr_top gocr_asserts #(.NUM_OUT(NUM_OUT)) u_ast (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_mask(sync_mask), .sync_stall(sync_stall), .sync_start(sync_start),
    .sync_restart(sync_restart), .output_analog_pll_cal_req(output_analog_pll_cal_req), .output_analog_pll_cal_start(output_analog_pll_cal_start),
    .system_clock_pll_cal_start(system_clock_pll_cal_start), .ref_monitor_fault(ref_monitor_fault),
    .ref_monitor_bypass(ref_monitor_bypass), .ref_faulted(ref_faulted),
    .ref_valid_now(ref_valid_now));

// file: tb_top.sv
// Purpose: Self-checking bench of the global control bank.
// Assumes: APB driven and answered at rising edges, other outputs seen at falling edges.
// Notes: Sticky monitors catch one-cycle pulses after each strobe.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, clr;
    logic sync_start, sync_restart, system_clock_pll_cal_start, device_sleep;
    logic seen_st, seen_rs, seen_sys;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic [7:0] sync_mask, sync_stall, m;
    logic [3:0] b, f;
    logic [3:0] output_analog_pll_cal_req, output_analog_pll_cal_start, ref_power_down, ref_monitor_fault;
    logic [3:0] ref_monitor_bypass, ref_faulted, ref_usable, ref_valid_now, seen_output_analog_pll, seen_vld;
    int errors, num_checks, seed;
    gocr_top #(.NUM_OUT(8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sync_mask(sync_mask), .sync_stall(sync_stall),
        .sync_start(sync_start), .sync_restart(sync_restart), .output_analog_pll_cal_req(output_analog_pll_cal_req),
        .output_analog_pll_cal_start(output_analog_pll_cal_start), .system_clock_pll_cal_start(system_clock_pll_cal_start),
        .device_sleep(device_sleep), .ref_power_down(ref_power_down),
        .ref_monitor_fault(ref_monitor_fault), .ref_monitor_bypass(ref_monitor_bypass),
        .ref_faulted(ref_faulted), .ref_usable(ref_usable), .ref_valid_now(ref_valid_now));
    // Clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        #500000;
        errors++;
        final_report();
    end
    // Sticky pulse monitors, cleared during a strobe or timeout setup
    always @(posedge pclk) begin
        seen_st <= !clr && (seen_st || sync_start);
        seen_rs <= !clr && (seen_rs || sync_restart);
        seen_sys <= !clr && (seen_sys || system_clock_pll_cal_start);
        seen_output_analog_pll <= clr ? 4'h0 : (seen_output_analog_pll | output_analog_pll_cal_start);
        seen_vld <= clr ? 4'h0 : (seen_vld | ref_valid_now);
    end
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Expected fault pattern: forced bits win over a monitor bypass
    function automatic logic [3:0] exp_flt(input logic [3:0] frc, input logic [3:0] mon,
        input logic [3:0] byp);
        return frc | (mon & ~byp);
    endfunction
    // One APB transfer; request held until pready is sampled high at an edge
    task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        clr <= w && (idx == gocr_pkg::IDX_XFER || idx == gocr_pkg::IDX_REF_TMO);
        @(posedge pclk);
        penable <= 1'b1;
        clr <= 1'b0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            errors++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h00000000);
        chk(rd, exp);
    endtask
    // Strobe write, then let derived outputs settle
    task automatic xfer(input logic [7:0] s);
        apb(1'b1, gocr_pkg::IDX_XFER, 32'(s));
        repeat (4) @(negedge pclk);
    endtask
    task automatic gset(input logic [7:0] g);
        apb(1'b1, gocr_pkg::IDX_GLOBAL, 32'(g));
        xfer(gocr_pkg::XFER_GO);
    endtask
    // Main sequence
    initial begin
        seed = 46356;
        {presetn, psel, penable, pwrite, clr} = '0;
        {paddr, pwdata, sync_mask, output_analog_pll_cal_req, ref_monitor_fault, ref_monitor_bypass} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        rdchk(gocr_pkg::IDX_GLOBAL, 32'h0);
        rdchk(gocr_pkg::IDX_REF_PD, 32'h0);
        rdchk(gocr_pkg::IDX_REF_TMO, 32'h0);
        rdchk(gocr_pkg::IDX_REF_FLT, 32'h0);
        apb(1'b0, 12'h123, 32'h0);
        chk(32'(err), 32'h1);
        $display("test reset done");
        v = $random(seed) | 32'h1;
        apb(1'b1, gocr_pkg::IDX_REF_PD, v);
        rdchk(gocr_pkg::IDX_REF_PD, v & 32'(gocr_pkg::MASK_LOW4));
        xfer(8'h03);
        chk(32'(ref_power_down), 32'h0);
        xfer(gocr_pkg::XFER_GO);
        chk(32'(ref_power_down), 32'(v[3:0]));
        apb(1'b1, gocr_pkg::IDX_REF_PD, 32'h0);
        xfer(gocr_pkg::XFER_GO);
        $display("test buffering done");
        m = 8'($random(seed));
        @(posedge pclk);
        sync_mask <= m;
        gset(8'h08);
        chk(32'(seen_st), 32'h1);
        chk(32'(sync_stall), {24'h000000, ~m});
        gset(8'h00);
        chk(32'(seen_rs), 32'h1);
        chk(32'(sync_stall), 32'h0);
        gset(8'h04);
        chk(32'(seen_sys), 32'h1);
        gset(8'h00);
        chk(32'(seen_sys), 32'h0);
        gset(8'h02);
        chk(32'(seen_output_analog_pll), 32'hF);
        chk(32'(seen_sys), 32'h1);
        @(posedge pclk);
        output_analog_pll_cal_req <= 4'hF;
        xfer(gocr_pkg::XFER_GO);
        chk(32'(seen_output_analog_pll), 32'h0);
        rdchk(gocr_pkg::IDX_GLOBAL, 32'h2);
        gset(8'h00);
        chk(32'(seen_output_analog_pll), 32'hF);
        @(posedge pclk);
        output_analog_pll_cal_req <= 4'h0;
        gset(8'h01);
        chk(32'(device_sleep), 32'h1);
        apb(1'b1, gocr_pkg::IDX_GLOBAL, 32'h0);
        xfer(8'h03);
        chk(32'(device_sleep), 32'h1);
        xfer(gocr_pkg::XFER_GO);
        chk(32'(device_sleep), 32'h0);
        $display("test global done");
        b = 4'($random(seed)) | 4'h3;
        f = exp_flt(4'h5, 4'hF, b);
        @(posedge pclk);
        ref_monitor_fault <= 4'hF;
        ref_monitor_bypass <= b;
        apb(1'b1, gocr_pkg::IDX_REF_FLT, 32'h05);
        xfer(gocr_pkg::XFER_GO);
        chk(32'(ref_faulted), 32'(f));
        chk(32'(ref_usable), {28'h0000000, ~f});
        rdchk(gocr_pkg::IDX_STATUS, {24'h000000, ~f, f});
        apb(1'b1, gocr_pkg::IDX_REF_TMO, 32'hFF);
        repeat (4) @(negedge pclk);
        chk(32'(seen_vld), {28'h0000000, ~f});
        rdchk(gocr_pkg::IDX_REF_TMO, 32'h0);
        @(posedge pclk);
        ref_monitor_fault <= 4'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        rdchk(gocr_pkg::IDX_REF_FLT, 32'h0);
        $display("test references done");
        final_report();
    end
endmodule
